// ===== verif/rcp_cmd_parser_assertions.sv
/* port checker of the remote command parser.
   assumes one clock and binding onto rcp_cmd_parser. */
`timescale 1ns/1ps
`include "rcp_map.vh"

module rcp_cmd_parser_assertions (
  input wire       clk,
  input wire       rst_n,
  input wire       rx_valid,
  input wire [7:0] rx_data,
  input wire       tx_valid_ff,
  input wire [7:0] tx_data_ff,
  input wire       tx_ready,
  input wire       serial_setpoint,
  input wire       alarm_active,
  input wire       nv_write_ff,
  input wire       run_ff,
  input wire       remote_stop_ff,
  input wire       alarm_contact_ff,
  input wire       valve_on_ff,
  input wire       frame_drop_ff
);
  // internal reset lags rst_n by two edges; up waits three
  reg  [1:0] up_ff;
  wire       up    = (up_ff == 2'h3);
  wire       cr_in = rx_valid && (rx_data == `RCP_CH_CR);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      up_ff <= 2'h0;
    else if (up_ff != 2'h3)
      up_ff <= up_ff + 2'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence byte_taken_s;
    tx_valid_ff && tx_ready;
  endsequence

  alarm_follow_a: assert property (up |-> alarm_contact_ff == $past(alarm_active))
    else $error("alarm contact does not follow alarm");
  valve_follow_a: assert property (up |-> valve_on_ff == $past(run_ff))
    else $error("valve output does not follow run state");
  reply_lf_a: assert property (byte_taken_s ##0 tx_data_ff != `RCP_CH_LF
    |=> tx_valid_ff && tx_data_ff == `RCP_CH_LF)
    else $error("reply digit not followed by line feed");
  reply_end_a: assert property (byte_taken_s ##0 tx_data_ff == `RCP_CH_LF |=> !tx_valid_ff)
    else $error("reply continues after line feed");
  reply_hold_a: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
    else $error("reply byte changed before accepted");
  no_unsolicited_a: assert property (up && $rose(tx_valid_ff) |-> $past(cr_in) || $past(cr_in, 2))
    else $error("reply started without a frame end");
  drop_keeps_a: assert property (frame_drop_ff |-> !nv_write_ff && $stable(run_ff))
    else $error("dropped frame changed state");
  local_quiet_a: assert property ((!serial_setpoint)[*4] ##0 up
    |-> !nv_write_ff && !remote_stop_ff)
    else $error("setting taken outside remote mode");
  remote_entry_a: assert property (up && $rose(serial_setpoint)
    |-> ##[1:3] (remote_stop_ff && !run_ff))
    else $error("remote entry did not stop the unit");
  run_excl_a: assert property (run_ff |-> !remote_stop_ff)
    else $error("running while remote stop shown");
endmodule // rcp_cmd_parser_assertions

bind rcp_cmd_parser rcp_cmd_parser_assertions rcp_cmd_parser_assertions_i (
  .clk, .rst_n, .rx_valid, .rx_data, .tx_valid_ff, .tx_data_ff, .tx_ready,
  .serial_setpoint, .alarm_active, .nv_write_ff, .run_ff, .remote_stop_ff,
  .alarm_contact_ff, .valve_on_ff, .frame_drop_ff
);

// ===== verif/rcp_host_model.sv
/* host computer model: sends command frames, takes reply bytes.
   assumes the bench calls send() and reads reply_q. */
`timescale 1ns/1ps

module rcp_host_model #(
  parameter GAP = 4
) (
  input  wire       clk,
  input  wire       slow,
  input  wire       tx_valid_ff,
  input  wire [7:0] tx_data_ff,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        tx_ready
);
  reg [7:0] reply_q [$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // slow host stalls every other cycle
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid_ff && tx_ready)
      reply_q.push_back(tx_data_ff);
  end

  task send(input string s);
    integer i;
    for (i = 0; i <= s.len(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= (i == s.len()) ? 8'h0d : s[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    repeat (GAP) @(posedge clk);
  endtask
endmodule // rcp_host_model

// ===== verif/test_ascii_remote_command_parser.sv
/* self-checking bench of the remote command parser.
   assumes the host model and a 200 MHz clock. */
`timescale 1ns/1ps

module test_ascii_remote_command_parser;
  reg        clk;
  reg        rst_n;
  reg        serial_setpoint;
  reg        local_run;
  reg        alarm_active;
  reg        slow;
  reg  [1:0] nv_sp_sel;
  reg  [1:0] nv_tune;
  reg        nv_prog_current;
  reg        nv_ext_ctrl;
  reg [31:0] rnd;
  wire       rx_valid;
  wire [7:0] rx_data;
  wire       tx_valid_ff;
  wire [7:0] tx_data_ff;
  wire       tx_ready;
  wire [1:0] sp_sel_ff;
  wire [1:0] tune_ff;
  wire       prog_current_ff, ext_ctrl_ff, run_ff, remote_stop_ff;
  wire       nv_write_ff, alarm_contact_ff, valve_on_ff, frame_drop_ff;
  integer    n_errors, n_compared, n_drop, exp_drop, rstop, seed, n, v, k;
  integer    n_nvw, exp_nvw;
  integer    m [1:5];

  rcp_cmd_parser rcp_cmd_parser_i (
    .clk, .rst_n, .rx_valid, .rx_data, .tx_valid_ff, .tx_data_ff, .tx_ready,
    .serial_setpoint, .local_run, .alarm_active, .nv_sp_sel, .nv_tune,
    .nv_prog_current, .nv_ext_ctrl, .nv_write_ff, .sp_sel_ff, .tune_ff,
    .prog_current_ff, .ext_ctrl_ff, .run_ff, .remote_stop_ff,
    .alarm_contact_ff, .valve_on_ff, .frame_drop_ff
  );
  rcp_host_model host_i (
    .clk, .slow, .tx_valid_ff, .tx_data_ff, .rx_valid, .rx_data, .tx_ready
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    rnd = $random(seed);
    alarm_active <= rnd[0];
    if (frame_drop_ff === 1'b1)
      n_drop <= n_drop + 1;
    if (nv_write_ff === 1'b1)
      n_nvw <= n_nvw + 1;
  end

  ////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input integer exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task check_all;
    #1;
    check(sp_sel_ff, m[1]);
    check(tune_ff, m[2]);
    check(prog_current_ff, m[3]);
    check(ext_ctrl_ff, m[4]);
    check(run_ff, m[5]);
    check(remote_stop_ff, rstop);
    check(n_drop[7:0], exp_drop);
    check(n_nvw[7:0], exp_nvw);
    check(valve_on_ff, m[5]);
    check(host_i.reply_q.size(), 0);
  endtask

  // model: v is the value the frame stands for, -1 when malformed
  task do_set(input string f, input integer n, input integer v);
    host_i.send(f);
    if (v < 0 || v > ((n <= 2) ? 2 : 1))
      exp_drop = exp_drop + 1;
    else if (serial_setpoint) begin
      m[n] = v;
      if (n == 5)
        rstop = 1 - v;
      else
        exp_nvw = exp_nvw + 1;
    end
    check_all;
  endtask

  task query(input string f, input integer n);
    integer i;
    host_i.send(f);
    for (i = 0; i < 60 && host_i.reply_q.size() < 2; i++)
      @(posedge clk);
    check(host_i.reply_q.size(), 2);
    check(host_i.reply_q.pop_front(), 48 + m[n]);
    check(host_i.reply_q.pop_front(), 10);
  endtask

  task pulse_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    m[1] = nv_sp_sel;
    m[2] = nv_tune;
    m[3] = nv_prog_current;
    m[4] = nv_ext_ctrl;
    m[5] = 0;
  endtask

  task report_and_stop;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    {n_errors, n_compared, n_drop, exp_drop, rstop, n_nvw, exp_nvw} = 0;
    seed = 32'h000a;
    rst_n = 1'b0;
    {serial_setpoint, local_run, alarm_active, slow} = 4'h0;
    {nv_sp_sel, nv_tune, nv_prog_current, nv_ext_ctrl} = 6'h26;
    pulse_reset;
    check_all;
    local_run <= 1'b1;
    m[5] = 1;
    do_set("out_mode_01 1", 1, 1);       // ignored
    do_set("out_mode_05 0", 5, 0);
    serial_setpoint <= 1'b1;
    m[5] = 0;
    rstop = 1;
    repeat (4) @(posedge clk);
    check_all;
    for (n = 1; n <= 5; n++)
      for (v = 0; v <= 2; v++) begin
        do_set($sformatf("out_mode_0%0d %0d", n, v), n, v);
        query($sformatf("in_mode_0%0d", n), n);
      end
    do_set("out_mode_01 1.0", 1, 1);
    do_set("out_mode_02 1.5", 2, -1);
    do_set("out_mode_06 1", 1, -1);
    do_set("out_mode_1 0", 1, -1);
    do_set("out_mode_03 x", 3, -1);
    do_set("out_mode_01 16", 1, -1);
    do_set("", 1, -1);
    query("in_mode_05 ", 5);
    slow <= 1'b1;
    for (k = 0; k < 12; k++) begin
      n = 1 + {$random(seed)} % 5;
      v = {$random(seed)} % 4;
      do_set($sformatf("out_mode_0%0d %0d", n, v), n, v);
      query($sformatf("in_mode_0%0d", n), n);
    end
    do_set("out_mode_05 1", 5, 1);
    local_run <= 1'b0;
    pulse_reset;
    #1;
    check(run_ff, 0);
    check(sp_sel_ff, nv_sp_sel);
    serial_setpoint <= 1'b0;
    rstop = 0;
    repeat (4) @(posedge clk);
    check_all;
    report_and_stop;
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_errors = n_errors + 1;
    report_and_stop;
  end
endmodule // test_ascii_remote_command_parser

// ===== verilog/rcp_cmd_parser.v
/*
 * Remote command parser of the recirculating cooler: takes received frame
 * bytes, decodes mode setting and mode query commands, holds the settings,
 * the run state and the reply stream.
 * Assumes rx bytes come from a serial receiver on clk, one per strobe,
 * and that the storage outside answers nv_* from power on.
 */
`timescale 1ns/1ps
`include "rcp_map.vh"

module rcp_cmd_parser (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       rx_valid,
  input  wire [7:0] rx_data,
  output reg        tx_valid_ff,
  output reg  [7:0] tx_data_ff,
  input  wire       tx_ready,
  input  wire       serial_setpoint,
  input  wire       local_run,
  input  wire       alarm_active,
  input  wire [1:0] nv_sp_sel,
  input  wire [1:0] nv_tune,
  input  wire       nv_prog_current,
  input  wire       nv_ext_ctrl,
  output reg        nv_write_ff,
  output reg  [1:0] sp_sel_ff,
  output reg  [1:0] tune_ff,
  output reg        prog_current_ff,
  output reg        ext_ctrl_ff,
  output reg        run_ff,
  output reg        remote_stop_ff,
  output reg        alarm_contact_ff,
  output reg        valve_on_ff,
  output reg        frame_drop_ff
);

  reg        rst_s1_ff;
  reg        rst_s2_ff;
  reg  [1:0] ps_ff;
  reg  [3:0] val_ff;
  reg        has_dig_ff;
  reg        in_frac_ff;
  reg        frac_nz_ff;
  reg  [1:0] ts_ff;
  reg        load_ff;
  reg        remote_ff;

  wire       out_hit;
  wire       in_hit;
  wire [7:0] out_dig;
  wire [7:0] in_dig;
  wire       is_cr;
  wire       is_sp;
  wire       is_dig;
  wire       is_dot;
  wire       match_stb;
  wire       match_clr;
  wire [3:0] dig_val;

  reg        do_set;
  reg        do_query;
  reg        do_drop;
  reg  [3:0] lim;
  reg  [7:0] q_val;
  reg  [7:0] mode;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // character classes
  assign is_cr  = (rx_data == `RCP_CH_CR);
  assign is_sp  = (rx_data == `RCP_CH_SP);
  assign is_dot = (rx_data == `RCP_CH_DOT);
  assign is_dig = (rx_data >= `RCP_CH_ZERO) && (rx_data <= `RCP_CH_NINE);
  assign dig_val = rx_data[3:0];

  assign match_stb = rx_valid && (ps_ff == `RCP_PS_KW) && !is_cr && !is_sp;
  assign match_clr = rx_valid && is_cr;

  rcp_prefix_match #(
    .LEN (`RCP_OUT_LEN),
    .PAT (`RCP_OUT_PAT)
  ) u_out_match (
    .clk   (clk),
    .rst_n (rst_s2_ff),
    .clr   (match_clr),
    .stb   (match_stb),
    .ch    (rx_data),
    .hit   (out_hit),
    .digit (out_dig)
  );

  rcp_prefix_match #(
    .LEN (`RCP_IN_LEN),
    .PAT (`RCP_IN_PAT)
  ) u_in_match (
    .clk   (clk),
    .rst_n (rst_s2_ff),
    .clr   (match_clr),
    .stb   (match_stb),
    .ch    (rx_data),
    .hit   (in_hit),
    .digit (in_dig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame decision at the carriage return
  always @* begin
    do_set   = 1'b0;
    do_query = 1'b0;
    do_drop  = 1'b0;
    mode     = out_hit ? out_dig : in_dig;
    case (mode)
      `RCP_MODE_SP:   lim = `RCP_MAX_SP;
      `RCP_MODE_TUNE: lim = `RCP_MAX_TUNE;
      default:        lim = `RCP_MAX_BIT;
    endcase
    case (mode)
      `RCP_MODE_SP:   q_val = {6'h00, sp_sel_ff};
      `RCP_MODE_TUNE: q_val = {6'h00, tune_ff};
      `RCP_MODE_PROG: q_val = {7'h00, prog_current_ff};
      `RCP_MODE_SRC:  q_val = {7'h00, ext_ctrl_ff};
      default:        q_val = {7'h00, run_ff};
    endcase
    if (rx_valid && is_cr) begin
      if (ps_ff == `RCP_PS_DROP) begin
        do_drop = 1'b1;
      end else if (out_hit && (mode >= `RCP_MODE_SP) && (mode <= `RCP_MODE_RUN)
                   && has_dig_ff && !frac_nz_ff && (val_ff <= lim)) begin
        // out of remote the frame is ignored
        do_set = remote_ff;
      end else if (in_hit && (mode >= `RCP_MODE_SP) && (mode <= `RCP_MODE_RUN)
                   && !has_dig_ff && !in_frac_ff) begin
        // a query during a running reply is lost, not queued
        do_query = (ts_ff == `RCP_TS_IDLE);
      end else begin
        do_drop = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame structure walk
  always @(posedge clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      ps_ff      <= `RCP_PS_KW;
      val_ff     <= 4'h0;
      has_dig_ff <= 1'b0;
      in_frac_ff <= 1'b0;
      frac_nz_ff <= 1'b0;
    end else if (rx_valid) begin
      if (is_cr) begin
        ps_ff      <= `RCP_PS_KW;
        val_ff     <= 4'h0;
        has_dig_ff <= 1'b0;
        in_frac_ff <= 1'b0;
        frac_nz_ff <= 1'b0;
      end else begin
        case (ps_ff)
          `RCP_PS_KW: begin
            if (is_sp) begin
              ps_ff <= `RCP_PS_PRM;
            end
          end
          `RCP_PS_PRM: begin
            if (is_dig) begin
              has_dig_ff <= 1'b1;
              if (in_frac_ff) begin
                if (dig_val != 4'h0) begin
                  frac_nz_ff <= 1'b1;
                end
              end else if (val_ff != 4'h0) begin
                // saturate: two significant digits exceed every limit
                val_ff <= 4'hf;
              end else begin
                val_ff <= dig_val;
              end
            end else if (is_dot && !in_frac_ff) begin
              in_frac_ff <= 1'b1;
            end else begin
              ps_ff <= `RCP_PS_DROP;
            end
          end
          default: begin
            ps_ff <= `RCP_PS_DROP;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings and run state
  always @(posedge clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      load_ff         <= 1'b1;
      remote_ff       <= 1'b0;
      sp_sel_ff       <= `RCP_RST_SP;
      tune_ff         <= `RCP_RST_TUNE;
      prog_current_ff <= 1'b0;
      ext_ctrl_ff     <= 1'b0;
      run_ff          <= 1'b0;
      remote_stop_ff  <= 1'b0;
      nv_write_ff     <= 1'b0;
      frame_drop_ff   <= 1'b0;
      alarm_contact_ff <= 1'b0;
      valve_on_ff     <= 1'b0;
    end else begin
      load_ff       <= 1'b0;
      nv_write_ff   <= 1'b0;
      frame_drop_ff <= do_drop;
      remote_ff     <= serial_setpoint;
      alarm_contact_ff <= alarm_active;
      valve_on_ff   <= run_ff;
      if (load_ff) begin
        sp_sel_ff       <= nv_sp_sel;
        tune_ff         <= nv_tune;
        prog_current_ff <= nv_prog_current;
        ext_ctrl_ff     <= nv_ext_ctrl;
      end else if (do_set) begin
        case (mode)
          `RCP_MODE_SP: begin
            sp_sel_ff   <= val_ff[1:0];
            nv_write_ff <= 1'b1;
          end
          `RCP_MODE_TUNE: begin
            tune_ff     <= val_ff[1:0];
            nv_write_ff <= 1'b1;
          end
          `RCP_MODE_PROG: begin
            prog_current_ff <= val_ff[0];
            nv_write_ff     <= 1'b1;
          end
          `RCP_MODE_SRC: begin
            ext_ctrl_ff <= val_ff[0];
            nv_write_ff <= 1'b1;
          end
          default: begin
            run_ff         <= val_ff[0];
            remote_stop_ff <= !val_ff[0];
          end
        endcase
      end
      if (serial_setpoint && !remote_ff) begin
        run_ff         <= 1'b0;
        remote_stop_ff <= 1'b1;
      end else if (!serial_setpoint) begin
        run_ff         <= local_run;
        remote_stop_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply stream
  always @(posedge clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      ts_ff       <= `RCP_TS_IDLE;
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else begin
      case (ts_ff)
        `RCP_TS_IDLE: begin
          if (do_query) begin
            tx_data_ff  <= `RCP_CH_ZERO + q_val;
            tx_valid_ff <= 1'b1;
            ts_ff       <= `RCP_TS_DIG;
          end
        end
        `RCP_TS_DIG: begin
          if (tx_ready) begin
            tx_data_ff <= `RCP_CH_LF;
            ts_ff      <= `RCP_TS_LF;
          end
        end
        `RCP_TS_LF: begin
          if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= 8'h00;
            ts_ff       <= `RCP_TS_IDLE;
          end
        end
        default: begin
          tx_valid_ff <= 1'b0;
          ts_ff       <= `RCP_TS_IDLE;
        end
      endcase
    end
  end

endmodule // rcp_cmd_parser

// ===== verilog/rcp_map.vh
/*
 * Constants for the remote command parser: character codes, frame layout,
 * mode numbers, parameter limits and reset values of the settings.
 * Assumes it is included by bare name from the design files.
 */
`ifndef RCP_MAP_VH
`define RCP_MAP_VH

// frame characters
`define RCP_CH_SP      8'h20
`define RCP_CH_CR      8'h0d
`define RCP_CH_LF      8'h0a
`define RCP_CH_DOT     8'h2e
`define RCP_CH_ZERO    8'h30
`define RCP_CH_NINE    8'h39

// keyword prefixes, first character in the top byte
`define RCP_OUT_LEN    10
`define RCP_OUT_PAT    80'h6f75745f6d6f64655f30
`define RCP_IN_LEN     9
`define RCP_IN_PAT     72'h696e5f6d6f64655f30

// mode numbers carried by the last keyword digit
`define RCP_MODE_SP    8'h31
`define RCP_MODE_TUNE  8'h32
`define RCP_MODE_PROG  8'h33
`define RCP_MODE_SRC   8'h34
`define RCP_MODE_RUN   8'h35

// highest legal parameter per mode
`define RCP_MAX_SP     4'h2
`define RCP_MAX_TUNE   4'h2
`define RCP_MAX_BIT    4'h1

// setting reset values
`define RCP_RST_SP     2'h0
`define RCP_RST_TUNE   2'h0

// parser states
`define RCP_PS_KW      2'h0
`define RCP_PS_PRM     2'h1
`define RCP_PS_DROP    2'h2

// reply states
`define RCP_TS_IDLE    2'h0
`define RCP_TS_DIG     2'h1
`define RCP_TS_LF      2'h2

`endif

// ===== verilog/rcp_prefix_match.v
/*
 * Matches a fixed keyword prefix character by character and captures the
 * one character that follows it.
 * Assumes the caller strobes each keyword character once and clears
 * between frames.
 */
`timescale 1ns/1ps

module rcp_prefix_match #(
  parameter            LEN = 9,
  parameter [8*LEN-1:0] PAT = {LEN{8'h00}}
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clr,
  input  wire       stb,
  input  wire [7:0] ch,
  output wire       hit,
  output wire [7:0] digit
);

  reg  [4:0] idx_ff;
  reg        ok_ff;
  reg  [7:0] digit_ff;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_ff   <= 5'h00;
      ok_ff    <= 1'b1;
      digit_ff <= 8'h00;
    end else if (clr) begin
      idx_ff   <= 5'h00;
      ok_ff    <= 1'b1;
      digit_ff <= 8'h00;
    end else if (stb) begin
      if (idx_ff < LEN) begin
        if (ch != PAT[8*(LEN-1-idx_ff) +: 8]) begin
          ok_ff <= 1'b0;
        end
      end else if (idx_ff == LEN) begin
        digit_ff <= ch;
      end else begin
        // longer keywords are not ours
        ok_ff <= 1'b0;
      end
      if (idx_ff != 5'h1f) begin
        idx_ff <= idx_ff + 5'h01;
      end
    end
  end

  assign hit   = ok_ff && (idx_ff == LEN + 1);
  assign digit = digit_ff;

endmodule // rcp_prefix_match
